// ### design/rename_stall_event_counting.sv
// event selection and stall counter for alias and segment rename stalls
// Summary of operation
// - code D2 mask 02 adds one per partial register stall cycle.
// - code D2 mask 04 adds one per flag stall cycle, partial flag included.
// - a partial flag stall is the first flag read after the last writer touching flags it left.
// - code D2 mask 08 adds two for every status word write.
// - code D2 mask 0F adds one when any of the four alias stalls is present.
// - code D4 masks 01, 02, 04, 08 pick the four segment rename stalls.
// - code D4 mask 0F counts a rename stall of any of the four segments.
// - an update to a renamed, unretired segment stalls until it retires.
// - code D2 mask 01 adds one per read port stall cycle, retries included.
module rename_stall_event_counting
	import rsc_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// event selection
	input wire logic count_enable,
	input wire rsc_pkg::event_code_t event_code,
	input wire rsc_pkg::unit_mask_t unit_mask,
	input wire logic count_clear,
	// alias stage conditions
	input wire logic partial_register_stall_cycles,
	input wire logic reorder_read_port_stall,
	input wire logic other_flag_stall,
	// flag writer
	input wire logic flag_write_valid,
	input wire rsc_pkg::flag_mask_t flag_write_mask,
	// flag reader
	input wire logic flag_read_valid,
	input wire rsc_pkg::flag_mask_t flag_read_mask,
	// floating-point status word
	input wire logic fp_status_word_write,
	// segment updates
	input wire rsc_pkg::seg_vec_t seg_update,
	// segment retirements
	input wire rsc_pkg::seg_vec_t seg_retire,
	// counter
	output rsc_pkg::count_t event_count,
	// stall status
	output rsc_pkg::seg_vec_t seg_frontend_stall,
	output logic flag_stall_cycles
);
	import rsc_pkg::*;

	flag_mask_t untouched_flags;
	flag_mask_t flags_left;
	logic flag_write_partial;
	logic partial_flag_stall;

	logic fp_status_write_stall;
	logic alias_stage_stall_any;

	seg_vec_t seg_stall_event;
	logic seg_rename_stall_extra;
	logic seg_rename_stall_data;
	logic seg_rename_stall_f;
	logic seg_rename_stall_g;
	logic seg_rename_stall_any;

	logic code_alias;
	logic code_seg;
	logic mask_defined;
	logic selection_defined;
	logic alias_hit;
	logic alias_double;
	logic seg_hit;
	logic count_advance;
	count_t next_increment;

	seg_track_if segs [`SEG_N] ();

	genvar g;
	generate
		for (g = 0; g < `SEG_N; g++)
		begin : g_seg
			assign segs[g].update = seg_update[g];
			assign segs[g].retire = seg_retire[g];
			assign seg_stall_event[g] = segs[g].stall_start;
			assign seg_frontend_stall[g] = segs[g].stall;
			// each data segment keeps its own renamed copy
			seg_rename_tracker u_track (
				.clk_sys(clk_sys),
				.rst(rst),
				.seg(segs[g])
			);
		end
	endgenerate

	// a full write leaves nothing behind for a reader to trip over
	assign flag_write_partial = flag_write_valid &&
		(flag_write_mask != `FLAG_ALL);
	assign flags_left = flag_write_partial ? ~flag_write_mask :
		`FLAG_NONE;

	// only the very next flag reader can see the partial update
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			untouched_flags <= `FLAG_NONE;
		else if (flag_write_valid)
			untouched_flags <= flags_left;
		else if (flag_read_valid)
			untouched_flags <= `FLAG_NONE;
	end

	// reader in the writer's cycle sees the older writer's state
	assign partial_flag_stall = flag_read_valid &&
		|(flag_read_mask & untouched_flags);
	assign flag_stall_cycles = partial_flag_stall ||
		other_flag_stall;
	assign fp_status_write_stall = fp_status_word_write;
	// a status word write counts once here, not twice
	assign alias_stage_stall_any = reorder_read_port_stall ||
		partial_register_stall_cycles || flag_stall_cycles ||
		fp_status_write_stall;

	// one event per stall start, not per stalled cycle
	assign seg_rename_stall_extra = seg_stall_event[`SEG_EXTRA];
	assign seg_rename_stall_data = seg_stall_event[`SEG_DATA];
	assign seg_rename_stall_f = seg_stall_event[`SEG_F];
	assign seg_rename_stall_g = seg_stall_event[`SEG_G];
	// two segments starting together still make one event
	assign seg_rename_stall_any = |seg_stall_event;

	// only two event codes belong to this block
	assign code_alias = (event_code == `EV_ALIAS_STALL);
	assign code_seg = (event_code == `EV_SEG_STALL);

	// both groups share the same five legal unit masks
	always_comb
	begin
		mask_defined = 1'b0;
		unique case (unit_mask)
			`UM_BIT0,
			`UM_BIT1,
			`UM_BIT2,
			`UM_BIT3,
			`UM_ANY:
				mask_defined = 1'b1;
			default:
				mask_defined = 1'b0;
		endcase
	end

	assign selection_defined = (code_alias || code_seg) &&
		mask_defined;

	// alias stage group
	always_comb
	begin
		alias_hit = 1'b0;
		alias_double = 1'b0;
		unique case (unit_mask)
			`UM_BIT0:
				alias_hit = reorder_read_port_stall;
			`UM_BIT1:
				alias_hit = partial_register_stall_cycles;
			`UM_BIT2:
				alias_hit = flag_stall_cycles;
			`UM_BIT3:
			begin
				alias_hit = fp_status_write_stall;
				alias_double = fp_status_write_stall;
			end
			`UM_ANY:
				alias_hit = alias_stage_stall_any;
			default:
				alias_hit = 1'b0;
		endcase
	end

	// segment rename group
	always_comb
	begin
		seg_hit = 1'b0;
		unique case (unit_mask)
			`UM_BIT0:
				seg_hit = seg_rename_stall_extra;
			`UM_BIT1:
				seg_hit = seg_rename_stall_data;
			`UM_BIT2:
				seg_hit = seg_rename_stall_f;
			`UM_BIT3:
				seg_hit = seg_rename_stall_g;
			`UM_ANY:
				seg_hit = seg_rename_stall_any;
			default:
				seg_hit = 1'b0;
		endcase
	end

	// a status word write costs two so halving the count gives writes
	always_comb
	begin
		next_increment = `COUNT_ZERO;
		if (code_alias && alias_double)
			next_increment = `INC_TWO;
		else if (code_alias && alias_hit)
			next_increment = `INC_ONE;
		else if (code_seg && seg_hit)
			next_increment = `INC_ONE;
	end

	// undefined selections never touch the counter
	assign count_advance = count_enable && selection_defined;

	// clear beats enable so a fresh run never inherits a stale count
	// wraps silently; overflow handling sits outside this block
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			event_count <= `COUNT_ZERO;
		else if (count_clear)
			event_count <= `COUNT_ZERO;
		else if (count_advance)
			event_count <= event_count + next_increment;
	end
endmodule // rename_stall_event_counting

// ### design/rsc_defines.svh
// constants for the rename stall event counter
`ifndef RSC_DEFINES_SVH
`define RSC_DEFINES_SVH
`define EV_CODE_W 8
`define EV_MASK_W 8
`define EV_ALIAS_STALL 8'hD2
`define EV_SEG_STALL 8'hD4
`define UM_BIT0 8'h01
`define UM_BIT1 8'h02
`define UM_BIT2 8'h04
`define UM_BIT3 8'h08
`define UM_ANY 8'h0F
`define COUNT_W 48
`define COUNT_ZERO 48'h0
`define INC_ONE 48'h1
`define INC_TWO 48'h2
`define FLAG_W 6
`define FLAG_NONE 6'h0
`define FLAG_ALL 6'h3F
`define SEG_N 4
`define SEG_EXTRA 0
`define SEG_DATA 1
`define SEG_F 2
`define SEG_G 3
`endif

// ### design/rsc_pkg.sv
// types for the rename stall event counter
`include "rsc_defines.svh"
package rsc_pkg;
	typedef logic [`EV_CODE_W-1:0] event_code_t;
	typedef logic [`EV_MASK_W-1:0] unit_mask_t;
	typedef logic [`COUNT_W-1:0] count_t;
	typedef logic [`FLAG_W-1:0] flag_mask_t;
	typedef logic [`SEG_N-1:0] seg_vec_t;
	typedef enum logic [1:0] {seg_free, seg_renamed, seg_stalled} seg_state_t;
endpackage

// ### design/seg_track_if.sv
// carrier between the counter and one segment rename tracker
interface seg_track_if;
	logic update;
	logic retire;
	logic stall;
	logic stall_start;
	modport tracker (input update, input retire, output stall,
		output stall_start);
	modport owner (output update, output retire, input stall,
		input stall_start);
endinterface

// ### design/seg_rename_tracker.sv
// renamed-but-not-retired tracking for one segment register
module seg_rename_tracker
	import rsc_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// segment activity
	seg_track_if.tracker seg
);
	seg_state_t state;

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			state <= seg_free;
		else
		begin
			unique case (state)
				seg_free:
					if (seg.update)
						state <= seg_renamed;
				seg_renamed:
					// a second update before retirement must wait
					if (seg.update && !seg.retire)
						state <= seg_stalled;
					else if (seg.retire && !seg.update)
						state <= seg_free;
				seg_stalled:
					// the held update takes the freed copy
					if (seg.retire)
						state <= seg_renamed;
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			seg.stall_start <= 1'b0;
		else
			seg.stall_start <= (state == seg_renamed) && seg.update &&
				!seg.retire;
	end

	assign seg.stall = (state == seg_stalled);
endmodule // seg_rename_tracker

// ### tb/rsc_checker.sv
// assertions on the stall event counter ports
module rsc_checker
(
	// watched ports
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic count_enable,
	input wire rsc_pkg::event_code_t event_code,
	input wire rsc_pkg::unit_mask_t unit_mask,
	input wire logic count_clear,
	input wire logic partial_register_stall_cycles,
	input wire logic reorder_read_port_stall,
	input wire logic fp_status_word_write,
	input wire rsc_pkg::seg_vec_t seg_retire,
	input wire rsc_pkg::count_t event_count,
	input wire rsc_pkg::seg_vec_t seg_frontend_stall,
	input wire logic flag_stall_cycles
);
	timeunit 1ns / 1ns;
	import rsc_pkg::*;
	count_t last;
	wire en = count_enable && !count_clear;
	wire d2 = en && event_code == 8'hD2;
	wire d4 = en && event_code == 8'hD4;
	wire pr = partial_register_stall_cycles;
	wire rb = reorder_read_port_stall;
	wire fw = fp_status_word_write;
	wire an = pr | rb | flag_stall_cycles | fw;
	wire s0 = seg_frontend_stall[0];
	// no reset: only read while the properties are enabled
	always_ff @(posedge clk_sys)
		last <= event_count;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	property p_par;
		d2 && unit_mask == 8'h02 |=> event_count - last == $past(pr);
	endproperty
	a_par: assert property (p_par) else $error("partial count");
	property p_flg;
		d2 && unit_mask == 8'h04 |=>
			event_count - last == $past(flag_stall_cycles);
	endproperty
	a_flg: assert property (p_flg) else $error("flag count");
	property p_fp;
		d2 && unit_mask == 8'h08 |=> event_count - last == 2 * $past(fw);
	endproperty
	a_fp: assert property (p_fp) else $error("status count");
	property p_any;
		d2 && unit_mask == 8'h0F |=> event_count - last == $past(an);
	endproperty
	a_any: assert property (p_any) else $error("any count");
	property p_rob;
		d2 && unit_mask == 8'h01 |=> event_count - last == $past(rb);
	endproperty
	a_rob: assert property (p_rob) else $error("read port count");
	property p_seg;
		s0 && !seg_retire[0] |=> s0;
	endproperty
	a_seg: assert property (p_seg) else $error("stall dropped");
	property p_sg1;
		d4 && unit_mask == 8'h01 && $rose(s0) |=> event_count - last == 1;
	endproperty
	a_sg1: assert property (p_sg1) else $error("segment count");
	property p_bad;
		en && event_code != 8'hD2 && event_code != 8'hD4 |=>
			$stable(event_count);
	endproperty
	a_bad: assert property (p_bad) else $error("stray count");
endmodule // rsc_checker

// ### tb/pipe_model.sv
// pipeline model reporting stall conditions
module pipe_model
(
	// clock
	input wire logic clk_sys,
	// conditions: partial, read port, other flag, status write
	output logic [3:0] cond,
	output logic [3:0] upd,
	output logic [3:0] ret,
	output logic [6:0] fwr,
	output logic [6:0] frd
);
	timeunit 1ns / 1ns;
	initial {cond, upd, ret, fwr, frd} = '0;
	// one cycle per call, changed off the sampling edge
	task automatic step(input logic [3:0] c, u, r, input logic [6:0] w, d);
		@(negedge clk_sys);
		{cond, upd, ret, fwr, frd} = {c, u, r, w, d};
	endtask
endmodule // pipe_model

// ### tb/rename_stall_event_counting_tb.sv
// testbench for the stall event counter
module rename_stall_event_counting_tb;
	timeunit 1ns / 1ns;
	import rsc_pkg::*;
	logic clk_sys = 0, rst = 1, count_enable = 0, count_clear = 0;
	event_code_t event_code = '0;
	unit_mask_t unit_mask = '0;
	logic [3:0] cond, upd, ret;
	logic [6:0] fwr, frd;
	count_t event_count;
	seg_vec_t seg_frontend_stall;
	logic flag_stall_cycles;
	int n_errors = 0, cmp_count = 0;
	always #5 clk_sys = ~clk_sys;
	pipe_model pm (.clk_sys, .cond, .upd, .ret, .fwr, .frd);
	rename_stall_event_counting dut (.clk_sys, .rst, .count_enable,
		.event_code, .unit_mask, .count_clear,
		.partial_register_stall_cycles(cond[3]),
		.reorder_read_port_stall(cond[2]), .other_flag_stall(cond[1]),
		.flag_write_valid(fwr[6]), .flag_write_mask(fwr[5:0]),
		.flag_read_valid(frd[6]), .flag_read_mask(frd[5:0]),
		.fp_status_word_write(cond[0]), .seg_update(upd), .seg_retire(ret),
		.event_count, .seg_frontend_stall, .flag_stall_cycles);
	task automatic cmp(input logic [47:0] got, exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED %0t got %0h exp %0h", $time, got, exp);
		end
	endtask
	task automatic sel(input logic [7:0] c, m);
		@(negedge clk_sys);
		{event_code, unit_mask, count_clear, count_enable} = {c, m, 2'b11};
		@(negedge clk_sys);
		count_clear = 0;
	endtask
	task automatic s_alias;
		logic [7:0] ms [8] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h0F, 8'h03,
			8'h10, 8'h01};
		int ex [8] = '{1, 1, 1, 2, 4, 0, 0, 0};
		for (int i = 0; i < 8; i++)
		begin
			sel(i == 7 ? 8'hD3 : 8'hD2, ms[i]);
			for (int k = 0; k < 4; k++)
				pm.step(4'h8 >> k, 0, 0, 0, 0);
			pm.step(0, 0, 0, 0, 0);
			cmp(event_count, ex[i]);
		end
	endtask
	task automatic s_flag;
		sel(8'hD2, 8'h04);
		pm.step(0, 0, 0, 7'h41, 0);
		pm.step(0, 0, 0, 0, 7'h42);
		#1 cmp(flag_stall_cycles, 1);
		pm.step(0, 0, 0, 0, 7'h42);
		#1 cmp(flag_stall_cycles, 0);
		pm.step(0, 0, 0, 7'h7F, 0);
		pm.step(0, 0, 0, 0, 7'h7F);
		#1 cmp(flag_stall_cycles, 0);
		pm.step(0, 0, 0, 0, 0);
		cmp(event_count, 1);
	endtask
	task automatic s_seg;
		for (int i = 0; i < 4; i++)
		begin
			sel(8'hD4, 4'h1 << i);
			repeat (2) pm.step(0, 4'h1 << i, 0, 0, 0);
			repeat (2) pm.step(0, 0, 0, 0, 0);
			cmp(seg_frontend_stall, 4'h1 << i);
			cmp(event_count, 1);
			repeat (2) pm.step(0, 0, 4'h1 << i, 0, 0);
			pm.step(0, 0, 0, 0, 0);
			cmp(seg_frontend_stall, 0);
		end
		sel(8'hD4, 8'h0F);
		repeat (2) pm.step(0, 4'h6, 0, 0, 0);
		pm.step(0, 0, 0, 0, 0);
		pm.step(0, 4'h6, 4'h6, 0, 0);
		cmp(event_count, 1);
		pm.step(0, 0, 4'h6, 0, 0);
		pm.step(0, 0, 0, 0, 0);
	endtask
	task automatic s_hold;
		sel(8'hD2, 8'h02);
		count_enable = 0;
		repeat (2) pm.step(4'h8, 0, 0, 0, 0);
		pm.step(0, 0, 0, 0, 0);
		cmp(event_count, 0);
		sel(8'hD4, 8'h10);
		repeat (2) pm.step(0, 4'h1, 0, 0, 0);
		repeat (2) pm.step(0, 0, 0, 0, 0);
		cmp(seg_frontend_stall, 4'h1);
		cmp(event_count, 0);
		rst = 1;
		@(negedge clk_sys);
		rst = 0;
		cmp(seg_frontend_stall, 0);
		cmp(event_count, 0);
	endtask
	task automatic print_verdict;
		if (n_errors == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		repeat (6) @(posedge clk_sys);
		@(negedge clk_sys);
		rst = 0;
		s_alias;
		s_flag;
		s_seg;
		s_hold;
		print_verdict;
	end
endmodule // rename_stall_event_counting_tb
bind rename_stall_event_counting rsc_checker chk (.clk_sys, .rst,
	.count_enable, .event_code, .unit_mask, .count_clear,
	.partial_register_stall_cycles, .reorder_read_port_stall,
	.fp_status_word_write, .seg_retire, .event_count, .seg_frontend_stall,
	.flag_stall_cycles);
